// ### rtl/sccd_defines.vh
// constants for the sensor compensation and diagnostics core
// Notes on behaviour
// - bridge drive shorted to bridge negative sets bridge, input and gain undervolt flags
// - bridge drive shorted to a sensor input sets input and gain overvolt flags
// - open sensor input or positive input to bridge negative: input and gain undervolt
// - differential temperature path, negative input open: temp input and gain overvolt
// - positive temp input open, or single-ended negative grounded: only temp gain undervolt
// - open bridge negative or shorted input pairs raise no flag
// - gain stage outputs compared against a window; violation sets fault bit
// - fault bits stay latched after the condition goes away
// - software reads a fault bit then writes zero to clear it
// - system reset clears all latched fault bits
// - programming the last memory byte recomputes checksum and updates match flag
// - recompute bit starts a checksum check; result goes to match flag
// - trim values checked at power-up; result in trim match flag
// - pressure is a0 times (adc plus b0); temperature is a1 times (adc plus b1)
// - output is sum over k of cubic-in-T polynomial times P to the k
// - compensation result limited between programmable low and high clamps
// - corrected output passes a second-order IIR into the output register
// - w(n)=a0 x+a1 w1+a2 w2; y=b0 w+b1 w1+b2 w2
// - revision identification is read-only and not unique per part
// - exactly two modes: running processes data, reset holds logic and outputs none
// - in running mode serial interfaces get no memory access, only message buffers
// - in reset mode serial interfaces may read and write memory
// - mode bit one holds the core in reset, zero lets it run
// - memory checksum is an 8-bit CRC whose running value starts at all ones
`ifndef SCCD_DEFINES_VH
`define SCCD_DEFINES_VH
`define SCCD_CRC_INIT 8'hff
`define SCCD_MEM_LAST 7'h7f
`define SCCD_FLT_IN_OV 0
`define SCCD_FLT_IN_UV 1
`define SCCD_FLT_TIN_OV 2
`define SCCD_FLT_PG_OV 4
`define SCCD_FLT_PG_UV 5
`define SCCD_FLT_TG_OV 6
`define SCCD_FLT_TG_UV 7
`define SCCD_FLT_MASK 8'hf7
`define SCCD_FRAC 14
`endif

// ### rtl/sccd_core.v
// sensor compensation, filter, fault latching and checksum core
`timescale 1ns/1ps
`include "sccd_defines.vh"
module sccd_core #(
  parameter W = 16,
  parameter MEM_DEPTH = 128,
  parameter [7:0] REV_ID = 8'h01 // arbitrary value
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // mode control
  input wire core_hold, // 1 holds processing in reset
  // front-end connectivity conditions, level inputs
  input wire short_brgp_brgn,
  input wire short_brgp_sens,
  input wire sens_open,
  input wire short_senp_brgn,
  input wire temp_diff_mode,
  input wire temp_neg_open,
  input wire temp_pos_open,
  input wire temp_neg_gnd,
  // gain stage outputs for window checks
  input wire [W-1:0] p_gain_level,
  input wire [W-1:0] t_gain_level,
  input wire [W-1:0] gain_win_low,
  input wire [W-1:0] gain_win_high,
  // fault register access
  input wire fault_wr,
  input wire [7:0] fault_wdata,
  output reg [7:0] front_end_fault_register,
  output reg bridge_supply_undervolt_flag,
  output wire bridge_fault_clear_ack,
  // serial interface memory port
  input wire mem_req,
  input wire mem_we,
  input wire [6:0] mem_addr,
  input wire [7:0] mem_wdata,
  output reg [7:0] mem_rdata,
  output wire mem_denied,
  input wire bridge_clear,
  // checksum control and status
  input wire recompute_checksum_bit,
  output reg crc_busy,
  output reg crc_match,
  output reg [7:0] crc_value,
  input wire [7:0] trim_crc_expect,
  input wire [7:0] trim_crc_actual,
  output reg trim_crc_match,
  output wire [7:0] revision_id,
  // coefficients
  input wire [W-1:0] gain_a0,
  input wire [W-1:0] gain_a1,
  input wire [W-1:0] offs_b0,
  input wire [W-1:0] offs_b1,
  input wire [16*W-1:0] poly_coef, // four h terms, then g, n and the last set, lowest first
  input wire [W-1:0] clamp_low,
  input wire [W-1:0] clamp_high,
  input wire [W-1:0] iir_a0,
  input wire [W-1:0] iir_a1,
  input wire [W-1:0] iir_a2,
  input wire [W-1:0] iir_b0,
  input wire [W-1:0] iir_b1,
  input wire [W-1:0] iir_b2,
  // sample stream in
  input wire p_valid,
  input wire [W-1:0] pressure_adc_result,
  input wire t_valid,
  input wire [W-1:0] temperature_adc_result,
  output wire in_ready,
  // filtered output stream
  output wire out_valid,
  output wire [W-1:0] out_data,
  input wire out_ready
);

  ////////////////////////////////////////////////////////////////////////
  // fixed point helpers

  // signed q.14 multiply with saturation to W bits
  function [W-1:0] fmul;
    input [W-1:0] x;
    input [W-1:0] y;
    reg signed [2*W-1:0] pr;
    reg signed [2*W-1:0] sh;
    begin
      pr = $signed(x) * $signed(y);
      sh = pr >>> `SCCD_FRAC;
      fmul = sat(sh);
    end
  endfunction

  // saturate a wide signed value into W bits
  function [W-1:0] sat;
    input [2*W-1:0] v;
    reg signed [2*W-1:0] s;
    begin
      s = v;
      if (s > $signed({{(W+1){1'b0}}, {(W-1){1'b1}}}))
        sat = {1'b0, {(W-1){1'b1}}};
      else if (s < $signed({{(W+1){1'b1}}, {(W-1){1'b0}}}))
        sat = {1'b1, {(W-1){1'b0}}};
      else
        sat = s[W-1:0];
    end
  endfunction

  // saturating signed add
  function [W-1:0] sadd;
    input [W-1:0] x;
    input [W-1:0] y;
    reg signed [2*W-1:0] s;
    begin
      s = $signed({{W{x[W-1]}}, x}) + $signed({{W{y[W-1]}}, y});
      sadd = sat(s);
    end
  endfunction

  // cubic in t by horner form
  function [W-1:0] cubic;
    input [4*W-1:0] c;
    input [W-1:0] t;
    begin
      cubic = sadd(fmul(sadd(fmul(sadd(fmul(c[4*W-1:3*W], t), c[3*W-1:2*W]), t),
        c[2*W-1:W]), t), c[W-1:0]);
    end
  endfunction

  // one crc8 step over a data byte
  function [7:0] crc_step;
    input [7:0] c;
    input [7:0] d;
    begin
      crc_step[0] = d[7]^d[6]^d[0]^c[0]^c[6]^c[7];
      crc_step[1] = d[6]^d[1]^d[0]^c[0]^c[1]^c[6];
      crc_step[2] = d[6]^d[2]^d[1]^d[0]^c[0]^c[1]^c[2]^c[6];
      crc_step[3] = d[7]^d[3]^d[2]^d[1]^c[1]^c[2]^c[3]^c[7];
      crc_step[4] = d[4]^d[3]^d[2]^c[2]^c[3]^c[4];
      crc_step[5] = d[5]^d[4]^d[3]^c[3]^c[4]^c[5];
      crc_step[6] = d[6]^d[5]^d[4]^c[4]^c[5]^c[6];
      crc_step[7] = d[7]^d[6]^d[5]^c[5]^c[6]^c[7];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // front-end faults

  reg [7:0] fault_set;
  wire p_win_bad;
  wire t_win_bad;
  assign p_win_bad = ($signed(p_gain_level) < $signed(gain_win_low)) ||
    ($signed(p_gain_level) > $signed(gain_win_high));
  assign t_win_bad = ($signed(t_gain_level) < $signed(gain_win_low)) ||
    ($signed(t_gain_level) > $signed(gain_win_high));
  assign revision_id = REV_ID;
  assign bridge_fault_clear_ack = bridge_clear & ~bridge_supply_undervolt_flag;

  // map connectivity conditions onto fault bits; unlisted faults set nothing
  always @* begin
    fault_set = 8'h00;
    if (short_brgp_brgn || sens_open || short_senp_brgn) begin
      fault_set[`SCCD_FLT_IN_UV] = 1'b1;
      fault_set[`SCCD_FLT_PG_UV] = 1'b1;
    end
    if (short_brgp_sens) begin
      fault_set[`SCCD_FLT_IN_OV] = 1'b1;
      fault_set[`SCCD_FLT_PG_OV] = 1'b1;
    end
    if (temp_diff_mode && temp_neg_open) begin
      fault_set[`SCCD_FLT_TIN_OV] = 1'b1;
      fault_set[`SCCD_FLT_TG_OV] = 1'b1;
    end
    if (temp_pos_open || (!temp_diff_mode && temp_neg_gnd))
      fault_set[`SCCD_FLT_TG_UV] = 1'b1;
    if (p_win_bad) begin
      fault_set[`SCCD_FLT_PG_UV] = 1'b1;
    end
    if (t_win_bad) begin
      fault_set[`SCCD_FLT_TG_UV] = 1'b1;
    end
  end

  // latched faults: a zero written clears, a set in the same cycle wins
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      front_end_fault_register <= 8'h00;
      bridge_supply_undervolt_flag <= 1'b0;
    end else begin
      if (fault_wr)
        front_end_fault_register <= ((front_end_fault_register & fault_wdata) | fault_set)
          & `SCCD_FLT_MASK;
      else
        front_end_fault_register <= (front_end_fault_register | fault_set)
          & `SCCD_FLT_MASK;
      if (short_brgp_brgn)
        bridge_supply_undervolt_flag <= 1'b1;
      else if (bridge_clear)
        bridge_supply_undervolt_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memory access and checksum

  reg [7:0] mem [0:MEM_DEPTH-1];
  reg [6:0] crc_idx;
  reg [7:0] crc_run;
  reg trim_done;
  wire mem_ok;
  wire last_write;
  assign mem_ok = mem_req & core_hold & ~crc_busy;
  assign mem_denied = mem_req & ~mem_ok;
  assign last_write = mem_ok & mem_we & (mem_addr == `SCCD_MEM_LAST);

  // memory array; only open to the serial side in reset mode
  always @(posedge clk) begin
    if (mem_ok && mem_we)
      mem[mem_addr] <= mem_wdata;
  end

  // read data register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      mem_rdata <= 8'h00;
    else if (mem_ok && !mem_we)
      mem_rdata <= mem[mem_addr];
  end

  // byte-serial crc walk over all bytes but the last, then compare
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_busy <= 1'b0;
      crc_match <= 1'b0;
      crc_idx <= 7'h00;
      crc_run <= `SCCD_CRC_INIT;
      crc_value <= 8'h00;
      trim_done <= 1'b0;
      trim_crc_match <= 1'b0;
    end else begin
      if (!trim_done) begin
        trim_done <= 1'b1;
        trim_crc_match <= (trim_crc_expect == trim_crc_actual);
      end
      if (!crc_busy) begin
        if (last_write || recompute_checksum_bit) begin
          crc_busy <= 1'b1;
          crc_idx <= 7'h00;
          crc_run <= `SCCD_CRC_INIT;
        end
      end else if (crc_idx == `SCCD_MEM_LAST) begin
        crc_busy <= 1'b0;
        crc_value <= crc_run;
        crc_match <= (crc_run == mem[`SCCD_MEM_LAST]);
      end else begin
        crc_run <= crc_step(crc_run, mem[crc_idx]);
        crc_idx <= crc_idx + 7'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compensation pipeline

  reg [W-1:0] p_hold;
  reg [W-1:0] t_hold;
  reg p_have;
  reg t_have;
  reg [W-1:0] ps;
  reg [W-1:0] ts;
  reg s1_valid;
  reg [W-1:0] comp;
  reg s2_valid;
  reg [W-1:0] w1;
  reg [W-1:0] w2;
  reg [W-1:0] next_w;
  reg [W-1:0] next_y;
  reg [W-1:0] poly_out;
  reg [W-1:0] p2;
  reg [W-1:0] p3;
  wire buf_in_ready;
  wire running;
  wire pair_go;
  assign running = ~core_hold;
  assign pair_go = running & p_have & t_have & buf_in_ready;
  assign in_ready = running & ~(p_have & t_have);

  // sum of cubic polynomials times powers of p, then clamp
  always @* begin
    p2 = fmul(ps, ps);
    p3 = fmul(p2, ps);
    poly_out = sadd(sadd(cubic(poly_coef[4*W-1:0], ts),
      fmul(cubic(poly_coef[8*W-1:4*W], ts), ps)),
      sadd(fmul(cubic(poly_coef[12*W-1:8*W], ts), p2),
      fmul(cubic(poly_coef[16*W-1:12*W], ts), p3)));
  end

  // iir direct form two
  always @* begin
    next_w = sadd(fmul(iir_a0, comp), sadd(fmul(iir_a1, w1), fmul(iir_a2, w2)));
    next_y = sadd(fmul(iir_b0, next_w), sadd(fmul(iir_b1, w1), fmul(iir_b2, w2)));
  end

  // pipeline registers; hold mode clears the valid flags and filter state, the data registers keep their values
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p_hold <= {W{1'b0}};
      t_hold <= {W{1'b0}};
      p_have <= 1'b0;
      t_have <= 1'b0;
      ps <= {W{1'b0}};
      ts <= {W{1'b0}};
      s1_valid <= 1'b0;
      comp <= {W{1'b0}};
      s2_valid <= 1'b0;
      w1 <= {W{1'b0}};
      w2 <= {W{1'b0}};
    end else if (!running) begin
      p_have <= 1'b0;
      t_have <= 1'b0;
      s1_valid <= 1'b0;
      s2_valid <= 1'b0;
      w1 <= {W{1'b0}};
      w2 <= {W{1'b0}};
    end else begin
      if (p_valid && !p_have) begin
        p_hold <= pressure_adc_result;
        p_have <= 1'b1;
      end else if (pair_go)
        p_have <= 1'b0;
      if (t_valid && !t_have) begin
        t_hold <= temperature_adc_result;
        t_have <= 1'b1;
      end else if (pair_go)
        t_have <= 1'b0;
      s1_valid <= pair_go;
      if (pair_go) begin
        ps <= fmul(gain_a0, sadd(p_hold, offs_b0));
        ts <= fmul(gain_a1, sadd(t_hold, offs_b1));
      end
      s2_valid <= s1_valid;
      if (s1_valid) begin
        if ($signed(poly_out) < $signed(clamp_low))
          comp <= clamp_low;
        else if ($signed(poly_out) > $signed(clamp_high))
          comp <= clamp_high;
        else
          comp <= poly_out;
      end
      if (s2_valid) begin
        w1 <= next_w;
        w2 <= w1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry output buffer

  reg [W-1:0] buf_data [0:1];
  reg buf_wp;
  reg buf_rp;
  reg [1:0] buf_cnt;
  wire buf_push;
  wire buf_pop;
  // only one pipeline word may be in flight, so entry needs both slots free and stages one and two idle
  assign buf_in_ready = (buf_cnt == 2'd0) & ~s1_valid & ~s2_valid;
  assign buf_push = s2_valid & running;
  assign buf_pop = out_valid & out_ready;
  assign out_valid = (buf_cnt != 2'd0) & running;
  assign out_data = buf_data[buf_rp];

  // buffer storage and pointers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_data[0] <= {W{1'b0}};
      buf_data[1] <= {W{1'b0}};
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'd0;
    end else if (!running) begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'd0;
    end else begin
      if (buf_push) begin
        buf_data[buf_wp] <= next_y;
        buf_wp <= ~buf_wp;
      end
      if (buf_pop)
        buf_rp <= ~buf_rp;
      buf_cnt <= buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

endmodule // sccd_core

// ### tb/sccd_core_checker.sv
// concurrent checks on the compensation core ports
`timescale 1ns/1ps
module sccd_core_checker #(
  parameter W = 16
) (
  // clock and reset
  input logic clk,
  input logic rst_n,
  // conditions and faults
  input logic core_hold,
  input logic short_brgp_brgn,
  input logic short_brgp_sens,
  input logic temp_diff_mode,
  input logic temp_neg_open,
  input logic fault_wr,
  input logic [7:0] front_end_fault_register,
  input logic bridge_supply_undervolt_flag,
  // memory, checksum and stream
  input logic mem_req,
  input logic mem_denied,
  input logic crc_busy,
  input logic out_valid,
  input logic out_ready,
  input logic [W-1:0] out_data
);
  ////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [7:0] fr = front_end_fault_register;
  // flags follow a condition within two edges
  a_bridge_short: assert property (
    short_brgp_brgn |-> ##[1:2] (bridge_supply_undervolt_flag && fr[1] && fr[5]))
    else $error("bridge short flags missing");
  a_input_short: assert property (
    short_brgp_sens |-> ##[1:2] (fr[0] && fr[4])) else $error("input short flags missing");
  a_temp_neg_open: assert property (
    temp_diff_mode && temp_neg_open |-> ##[1:2] (fr[2] && fr[6]))
    else $error("temp open flags missing");
  // without a write no set bit may drop
  a_fault_latch: assert property (
    !fault_wr |=> ((fr & $past(fr)) == $past(fr))) else $error("fault bit dropped");
  a_mem_running: assert property (
    mem_req && !core_hold |-> mem_denied) else $error("memory open while running");
  a_hold_quiet: assert property (
    core_hold [*2] |-> !out_valid) else $error("output while held");
  a_out_hold: assert property (
    out_valid && !out_ready && !core_hold |=> core_hold || (out_valid && $stable(out_data)))
    else $error("output word lost in stall");
  a_crc_bound: assert property (
    $rose(crc_busy) |-> ##[120:140] !crc_busy) else $error("checksum run length");
endmodule // sccd_core_checker

bind sccd_core sccd_core_checker #(.W(W)) sccd_core_checker_i (.clk, .rst_n, .core_hold,
  .short_brgp_brgn, .short_brgp_sens, .temp_diff_mode, .temp_neg_open, .fault_wr,
  .front_end_fault_register, .bridge_supply_undervolt_flag, .mem_req, .mem_denied,
  .crc_busy, .out_valid, .out_ready, .out_data);

// ### tb/sccd_sensor_model.sv
// far-side model: sensor sample source and output sink
`timescale 1ns/1ps
module sccd_sensor_model (
  // clock and stream handshakes
  input logic clk,
  input logic in_ready,
  input logic out_valid,
  input logic [15:0] out_data,
  input logic stall,
  output logic p_valid,
  output logic t_valid,
  output logic [15:0] pressure_adc_result,
  output logic [15:0] temperature_adc_result,
  output logic out_ready
);
  logic [15:0] got[$];
  // idle data lines carry the inverse of the last word, never a stale copy
  initial begin
    p_valid = 1'h0;
    t_valid = 1'h0;
    pressure_adc_result = 16'h0;
    temperature_adc_result = 16'h0;
  end
  assign out_ready = !stall;
  // words are taken at the edge where valid meets ready
  always @(posedge clk) begin
    if (out_valid && out_ready) got.push_back(out_data);
  end
  // pressure leads temperature by a cycle so pairing is exercised
  task send(input logic [15:0] p, input logic [15:0] t);
    int i;
    logic tp, tt;
    i = 0;
    p_valid = 1'h1;
    pressure_adc_result = p;
    while ((p_valid || t_valid) && i < 60) begin
      @(negedge clk);
      tp = p_valid && in_ready;
      tt = t_valid && in_ready;
      @(posedge clk);
      #1;
      if (i == 0) begin
        t_valid = 1'h1;
        temperature_adc_result = t;
      end
      if (tp) begin
        p_valid = 1'h0;
        pressure_adc_result = ~p;
      end
      if (tt) begin
        t_valid = 1'h0;
        temperature_adc_result = ~t;
      end
      i++;
    end
  endtask
endmodule // sccd_sensor_model

// ### tb/sccd_core_test.sv
// self-checking bench for the compensation core
`timescale 1ns/1ps
module sccd_core_test;
  // inputs, all valued at time zero
  logic clk, rst_n = 1'h0, core_hold = 1'h1, fault_wr = 1'h0, bridge_clear = 1'h0, stall = 1'h0;
  logic short_brgp_brgn = 1'h0, short_brgp_sens = 1'h0, sens_open = 1'h0, short_senp_brgn = 1'h0;
  logic temp_diff_mode = 1'h0, temp_neg_open = 1'h0, temp_pos_open = 1'h0, temp_neg_gnd = 1'h0;
  logic mem_req = 1'h0, mem_we = 1'h0, recompute_checksum_bit = 1'h0;
  logic [6:0] mem_addr = 7'h00;
  logic [7:0] fault_wdata = 8'h00, mem_wdata = 8'h00, trim_crc_expect = 8'h3c, trim_crc_actual = 8'h3c;
  logic [15:0] p_gain_level = 16'h0, t_gain_level = 16'h0, gain_win_low = 16'hfc18;
  logic [15:0] gain_win_high = 16'h03e8, gain_a0 = 16'h4000, gain_a1 = 16'h4000;
  logic [15:0] offs_b0 = 16'h0100, offs_b1 = 16'h0010, clamp_low = 16'hf000, clamp_high = 16'h1000;
  logic [15:0] iir_a0 = 16'h4000, iir_a1 = 16'h0, iir_a2 = 16'h0, iir_b0 = 16'h4000, iir_b1 = 16'h0;
  logic [15:0] iir_b2 = 16'h0;
  // output is h1*T + g0*P with every other coefficient zero
  logic [255:0] poly_coef = (256'h4000 << 64) | (256'h4000 << 16);
  // outputs
  logic bridge_supply_undervolt_flag, bridge_fault_clear_ack, mem_denied, crc_busy, crc_match;
  logic trim_crc_match, p_valid, t_valid, in_ready, out_valid, out_ready;
  logic [7:0] front_end_fault_register, mem_rdata, crc_value, revision_id, crc;
  logic [15:0] pressure_adc_result, temperature_adc_result, out_data;
  int fails = 0, check_count = 0, cyc = 0;
  // condition sets, bit 0 upward as in setc, and expected {bridge flag, faults}
  logic [9:0] cv[11] = '{10'h001, 10'h002, 10'h004, 10'h008, 10'h030, 10'h050, 10'h040,
    10'h080, 10'h010, 10'h100, 10'h200};
  logic [8:0] ev[11] = '{9'h122, 9'h011, 9'h022, 9'h022, 9'h044, 9'h080, 9'h080, 9'h080,
    9'h000, 9'h020, 9'h080};
  localparam logic [7:0] cm[8] = '{8'hc1, 8'h43, 8'h47, 8'h8e, 8'h1c, 8'h38, 8'h70, 8'he0};
  ////////////////////////////////////////
  sccd_core sccd_core_i (.*);
  sccd_sensor_model sccd_sensor_model_i (.clk(clk), .in_ready(in_ready), .out_valid(out_valid),
    .out_data(out_data), .stall(stall), .p_valid(p_valid), .t_valid(t_valid),
    .pressure_adc_result(pressure_adc_result), .temperature_adc_result(temperature_adc_result),
    .out_ready(out_ready));
  // 250 MHz clock
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // a hang is cut short well above the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_sim;
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // out-of-window gain level is 16'h4000, well past the 16'h03e8 bound
  task setc(input logic [9:0] c);
    {temp_neg_gnd, temp_pos_open, temp_neg_open, temp_diff_mode, short_senp_brgn, sens_open,
      short_brgp_sens, short_brgp_brgn} = c[7:0];
    p_gain_level = {1'h0, c[8], 14'h0};
    t_gain_level = {1'h0, c[9], 14'h0};
  endtask
  // request stays up between calls; a refused request is simply held
  task mem(input logic we, input logic [6:0] a, input logic [7:0] d);
    int i;
    logic ok;
    i = 0;
    ok = 1'h0;
    mem_req = 1'h1;
    mem_we = we;
    mem_addr = a;
    mem_wdata = d;
    while (!ok && i < 400) begin
      @(negedge clk);
      ok = !mem_denied;
      tick(1);
      i++;
    end
    chk("mem taken", ok, 16'h1);
  endtask
  task crcwait;
    int i;
    i = 0;
    while (!crc_busy && i < 5) begin
      tick(1);
      i++;
    end
    while (crc_busy && i < 400) begin
      tick(1);
      i++;
    end
    chk("crc busy", crc_busy, 16'h0);
  endtask
  task getout(input logic [15:0] e);
    int i;
    i = 0;
    while (sccd_sensor_model_i.got.size() == 0 && i < 60) begin
      tick(1);
      i++;
    end
    if (sccd_sensor_model_i.got.size() > 0) chk("output", sccd_sensor_model_i.got.pop_front(), e);
    else chk("output present", 16'h0, 16'h1);
  endtask
  // one byte step of the checksum, seeded with all ones by the caller
  function automatic logic [7:0] nx(input logic [7:0] c, input logic [7:0] d);
    for (int k = 0; k < 8; k++) nx[k] = ^((c ^ d) & cm[k]);
  endfunction
  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'h1;
    tick(2);
    chk("trim match", trim_crc_match, 16'h1);
    for (int i = 0; i < 11; i++) begin
      setc(cv[i]);
      tick(3);
      setc(10'h0);
      tick(3);
      chk("faults", front_end_fault_register, ev[i][7:0]);
      chk("bridge flag", bridge_supply_undervolt_flag, ev[i][8]);
      fault_wr = 1'h1;
      fault_wdata = 8'hff;
      tick(1);
      chk("kept faults", front_end_fault_register, ev[i][7:0]);
      fault_wdata = 8'h00;
      bridge_clear = 1'h1;
      tick(1);
      chk("clear ack", bridge_fault_clear_ack, 16'h1);
      fault_wr = 1'h0;
      bridge_clear = 1'h0;
      chk("cleared", {bridge_supply_undervolt_flag, front_end_fault_register}, 16'h0);
    end
    crc = 8'hff;
    for (int i = 0; i < 127; i++) begin
      mem(1'h1, i[6:0], i[7:0] ^ 8'h5a);
      crc = nx(crc, i[7:0] ^ 8'h5a);
    end
    mem(1'h1, 7'h7f, crc);
    mem_req = 1'h0;
    crcwait;
    chk("crc match", crc_match, 16'h1);
    chk("crc value", crc_value, crc);
    mem(1'h0, 7'h7f, 8'h00);
    mem_req = 1'h0;
    tick(1);
    chk("read back", mem_rdata, crc);
    mem(1'h1, 7'h00, 8'h00);
    mem_req = 1'h0;
    recompute_checksum_bit = 1'h1;
    tick(1);
    recompute_checksum_bit = 1'h0;
    crcwait;
    chk("recheck", crc_match, 16'h0);
    core_hold = 1'h0;
    mem_req = 1'h1;
    tick(1);
    chk("denied", mem_denied, 16'h1);
    mem_req = 1'h0;
    // offsets add 16'h0100 to pressure and 16'h0010 to temperature
    sccd_sensor_model_i.send(16'h0300, 16'h00f0);
    getout(16'h0500);
    sccd_sensor_model_i.send(16'h2000, 16'hfff0);
    getout(16'h1000);
    sccd_sensor_model_i.send(16'hc000, 16'hfff0);
    getout(16'hf000);
    core_hold = 1'h1;
    iir_a1 = 16'h2000;
    tick(2);
    core_hold = 1'h0;
    stall = 1'h1;
    sccd_sensor_model_i.send(16'h0300, 16'hfff0);
    tick(10);
    stall = 1'h0;
    getout(16'h0400);
    sccd_sensor_model_i.send(16'h0300, 16'hfff0);
    getout(16'h0600);
    core_hold = 1'h1;
    tick(2);
    core_hold = 1'h0;
    sccd_sensor_model_i.send(16'h0300, 16'hfff0);
    getout(16'h0400);
    trim_crc_actual = 8'h3d;
    short_brgp_brgn = 1'h1;
    tick(3);
    short_brgp_brgn = 1'h0;
    rst_n = 1'h0;
    tick(2);
    rst_n = 1'h1;
    tick(2);
    chk("reset faults", {bridge_supply_undervolt_flag, front_end_fault_register}, 16'h0);
    chk("trim bad", trim_crc_match, 16'h0);
    chk("revision", revision_id, 16'h01);
    end_sim;
  end
endmodule // sccd_core_test
